// ===== ucf_pkg.sv
// Constants, register map and state types of the serial clock and frame block.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
// Contract
// - Four clock modes; sync select 1 picks synchronous
// - Sync: pin direction output means master, input slave
// - Transfer clock pin used only in synchronous mode
// - Baud down-counter reloads at zero and low-byte write
// - One tick per zero; divisor range 0 to 4095
// - Transmit divides ticks by 16, 8 or 2
// - Receiver uses ticks directly with 16, 8 or 2 states
// - Double speed only affects asynchronous; software clears otherwise
// - Double speed receiver uses 8 samples per bit
// - Slave clock synchronised then edge detected, two cycles
// - Sync receive samples opposite the transmit change edge
// - Polarity clear: change rising, sample falling; else reversed
// - Accept all thirty frame formats
// - Start, data LSB first, parity, then stop bits
// - After last stop, next frame or idle high
// - Start low, stops high, idle line high
// - Transmitter and receiver share one format setting
// - Only first stop bit checked for frame error
// - One transmit buffer, two-level receive buffer
// - Receiver reports frame, overrun and parity errors
// - Three interrupt sources: done, buffer empty, received
// - Parity is xor of data; odd inverts it
// - Size code 7 gives nine bits from control bit
package ucf_pkg;
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_CTLB = 8'h08;
   localparam logic [7:0] OFF_CTLC = 8'h0c;
   localparam logic [7:0] OFF_BAUDL = 8'h10;
   localparam logic [7:0] OFF_BAUDH = 8'h14;
   // Status bits
   localparam int STAT_RXC = 7;
   localparam int STAT_TXC = 6;
   localparam int STAT_EMPTY = 5;
   localparam int STAT_FE = 4;
   localparam int STAT_DOR = 3;
   localparam int STAT_PE = 2;
   localparam int STAT_U2X = 1;
   // Control B bits
   localparam int CTLB_RXCIE = 7;
   localparam int CTLB_TXCIE = 6;
   localparam int CTLB_EMPTYIE = 5;
   localparam int CTLB_RXEN = 4;
   localparam int CTLB_TXEN = 3;
   localparam int CTLB_CSZ2 = 2;
   localparam int CTLB_NINTH_TRANSMIT_BIT = 0;
   // Control C bits
   localparam int CTLC_DIR = 7;
   localparam int CTLC_SYNC = 6;
   localparam int CTLC_PM_HI = 5;
   localparam int CTLC_PM_LO = 4;
   localparam int CTLC_STOP = 3;
   localparam int CTLC_CSZ_HI = 2;
   localparam int CTLC_CSZ_LO = 1;
   localparam int CTLC_POL = 0;
   localparam logic [7:0] CTLB_RST = 8'h00;
   localparam logic [7:0] CTLC_RST = 8'h06;
   localparam logic [11:0] BAUD_RST = 12'h000;
   // Samples per bit, expressed as last phase and mid phase
   localparam logic [3:0] LAST_NORM = 4'hf;
   localparam logic [3:0] LAST_DBL = 4'h7;
   localparam logic [3:0] MID_NORM = 4'h8;
   localparam logic [3:0] MID_DBL = 4'h4;
   localparam logic [1:0] PM_OFF = 2'h0;
   localparam logic [2:0] CSZ_NINE = 3'h7;
   localparam logic [2:0] CSZ_MAX_STD = 3'h3;
   localparam logic [3:0] BITS_MIN = 4'h5;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucf_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ucf_rx_t;
endpackage

// ===== ucf_top.sv
// Serial transceiver clock generation, frame sequencing and register slave.
// Assumes all pins synchronous to aclk except the slave transfer clock input.
`timescale 1ns/1ns
module ucf_top
   import ucf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Serial lines
   input wire logic serial_in_line,
   output logic serial_out_line,
   // Transfer clock pin
   input wire logic transfer_clock_pin_in,
   output logic transfer_clock_pin_out,
   output logic transfer_clock_pin_oe,
   // Event outputs
   output logic irq_tx_complete,
   output logic irq_buf_empty,
   output logic irq_rx_complete
);

   function automatic logic [8:0] data_mask(input logic [3:0] n);
      logic [8:0] m;
      m = '0;
      for (int i = 0; i < 9; i++)
      begin
         if (4'(i) < n)
         begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // Configuration and bus state
   logic u2x_r, u2x_nxt;
   logic [7:0] ctlb_r, ctlb_nxt, ctlc_r, ctlc_nxt;
   logic [11:0] baud_r, baud_nxt;
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [7:0] wa_r, wa_nxt;
   logic [7:0] wd_r, wd_nxt;
   logic ws_r, ws_nxt;
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic bvalid_nxt, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_go, baudl_wr, data_wr, stat_wr, pop;
   // Clock state
   logic [11:0] bcnt_r, bcnt_nxt;
   logic xck_r, xck_nxt, xck_oe_r, xck_oe_nxt;
   logic xs1_r, xs2_r, xs3_r;
   // Transmit state
   ucf_tx_t tx_st_r, tx_st_nxt;
   logic [8:0] txbuf_r, txbuf_nxt, txsh_r, txsh_nxt;
   logic txbuf_full_r, txbuf_full_nxt, txd_r, txd_nxt, txc_r, txc_nxt, txpar_r, txpar_nxt;
   logic [3:0] tx_idx_r, tx_idx_nxt, tx_ph_r, tx_ph_nxt;
   // Receive state
   ucf_rx_t rx_st_r, rx_st_nxt;
   logic [8:0] rxsh_r, rxsh_nxt;
   logic [3:0] rx_idx_r, rx_idx_nxt, rx_ph_r, rx_ph_nxt;
   logic rxpe_r, rxpe_nxt, dor_r, dor_nxt;
   logic [10:0] fifo_r [2], fifo_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;
   logic irq_txc_r, irq_emp_r, irq_rxc_r;

   // Shared mode decode
   logic sync, master, pol, dbl, tick, rise, fall, chg_edge, smp_edge, tx_bit, rx_smp;
   logic [2:0] csz;
   logic [3:0] nbits, last_ph, mid_ph;
   logic [1:0] pm;
   always_comb
   begin
      sync = ctlc_r[CTLC_SYNC];
      master = ctlc_r[CTLC_DIR];
      pol = ctlc_r[CTLC_POL];
      dbl = u2x_r & ~sync;
      pm = ctlc_r[CTLC_PM_HI:CTLC_PM_LO];
      csz = {ctlb_r[CTLB_CSZ2], ctlc_r[CTLC_CSZ_HI:CTLC_CSZ_LO]};
      if (csz == CSZ_NINE)
      begin
         nbits = BITS_NINE;
      end
      else if (csz <= CSZ_MAX_STD)
      begin
         nbits = BITS_MIN + {1'b0, csz};
      end
      else
      begin
         nbits = BITS_EIGHT;
      end
      last_ph = dbl ? LAST_DBL : LAST_NORM;
      mid_ph = dbl ? MID_DBL : MID_NORM;
      tick = (bcnt_r == '0);
      if (master)
      begin
         rise = tick & ~xck_r;
         fall = tick & xck_r;
      end
      else
      begin
         rise = xs2_r & ~xs3_r;
         fall = ~xs2_r & xs3_r;
      end
      chg_edge = pol ? fall : rise;
      smp_edge = pol ? rise : fall;
      tx_bit = sync ? chg_edge : (tick & (tx_ph_r == last_ph));
      rx_smp = sync ? smp_edge : (tick & (rx_ph_r == mid_ph));
   end

   // Register bus slave
   always_comb
   begin
      aw_full_nxt = aw_full_r;
      w_full_nxt = w_full_r;
      wa_nxt = wa_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      u2x_nxt = u2x_r;
      ctlb_nxt = ctlb_r;
      ctlc_nxt = ctlc_r;
      baud_nxt = baud_r;
      baudl_wr = 1'b0;
      data_wr = 1'b0;
      stat_wr = 1'b0;
      pop = 1'b0;
      if (awvalid && awready_r)
      begin
         aw_full_nxt = 1'b1;
         wa_nxt = awaddr;
      end
      if (wvalid && wready_r)
      begin
         w_full_nxt = 1'b1;
         wd_nxt = wdata[7:0];
         ws_nxt = wstrb[0];
      end
      if (bvalid_r && bready)
      begin
         bvalid_nxt = 1'b0;
      end
      wr_go = aw_full_r & w_full_r & ~bvalid_r;
      if (wr_go)
      begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         if (wa_r == OFF_DATA)
         begin
            data_wr = ws_r;
         end
         else if (wa_r == OFF_STAT)
         begin
            stat_wr = ws_r;
            u2x_nxt = ws_r ? wd_r[STAT_U2X] : u2x_r;
         end
         else if (wa_r == OFF_CTLB)
         begin
            ctlb_nxt = ws_r ? wd_r : ctlb_r;
         end
         else if (wa_r == OFF_CTLC)
         begin
            ctlc_nxt = ws_r ? wd_r : ctlc_r;
         end
         else if (wa_r == OFF_BAUDL)
         begin
            baudl_wr = ws_r;
            baud_nxt[7:0] = ws_r ? wd_r : baud_r[7:0];
         end
         else if (wa_r == OFF_BAUDH)
         begin
            baud_nxt[11:8] = ws_r ? wd_r[3:0] : baud_r[11:8];
         end
         else
         begin
            bresp_nxt = RESP_SLVERR;
         end
      end
      if (rvalid_r && rready)
      begin
         rvalid_nxt = 1'b0;
      end
      if (arvalid && arready_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         rdata_nxt = '0;
         if (araddr == OFF_DATA)
         begin
            pop = (cnt_r != '0);
            rdata_nxt[8:0] = pop ? fifo_r[0][8:0] : 9'h000;
         end
         else if (araddr == OFF_STAT)
         begin
            rdata_nxt[STAT_RXC] = (cnt_r != '0);
            rdata_nxt[STAT_TXC] = txc_r;
            rdata_nxt[STAT_EMPTY] = ~txbuf_full_r;
            rdata_nxt[STAT_FE] = (cnt_r != '0) & fifo_r[0][9];
            rdata_nxt[STAT_DOR] = dor_r;
            rdata_nxt[STAT_PE] = (cnt_r != '0) & fifo_r[0][10];
            rdata_nxt[STAT_U2X] = u2x_r;
         end
         else if (araddr == OFF_CTLB)
         begin
            rdata_nxt[7:0] = ctlb_r;
         end
         else if (araddr == OFF_CTLC)
         begin
            rdata_nxt[7:0] = ctlc_r;
         end
         else if (araddr == OFF_BAUDL)
         begin
            rdata_nxt[7:0] = baud_r[7:0];
         end
         else if (araddr == OFF_BAUDH)
         begin
            rdata_nxt[3:0] = baud_r[11:8];
         end
         else
         begin
            rresp_nxt = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         wa_r <= '0;
         wd_r <= '0;
         ws_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         arready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= '0;
         u2x_r <= 1'b0;
         ctlb_r <= CTLB_RST;
         ctlc_r <= CTLC_RST;
         baud_r <= BAUD_RST;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         wa_r <= wa_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
         awready_r <= ~aw_full_nxt;
         wready_r <= ~w_full_nxt;
         arready_r <= ~rvalid_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         u2x_r <= u2x_nxt;
         ctlb_r <= ctlb_nxt;
         ctlc_r <= ctlc_nxt;
         baud_r <= baud_nxt;
      end
   end

   // Baud generator and transfer clock
   always_comb
   begin
      bcnt_nxt = (tick || baudl_wr) ? baud_nxt : bcnt_r - 12'h001;
      xck_nxt = (sync && master && tick) ? ~xck_r : xck_r;
      xck_oe_nxt = sync & master;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bcnt_r <= BAUD_RST;
         xck_r <= 1'b0;
         xck_oe_r <= 1'b0;
         xs1_r <= 1'b0;
         xs2_r <= 1'b0;
         xs3_r <= 1'b0;
      end
      else
      begin
         bcnt_r <= bcnt_nxt;
         xck_r <= xck_nxt;
         xck_oe_r <= xck_oe_nxt;
         xs1_r <= transfer_clock_pin_in;
         xs2_r <= xs1_r;
         xs3_r <= xs2_r;
      end
   end

   // Transmitter
   always_comb
   begin
      logic load;
      load = 1'b0;
      tx_st_nxt = tx_st_r;
      txbuf_nxt = txbuf_r;
      txbuf_full_nxt = txbuf_full_r;
      txsh_nxt = txsh_r;
      txd_nxt = txd_r;
      txpar_nxt = txpar_r;
      tx_idx_nxt = tx_idx_r;
      tx_ph_nxt = tx_ph_r;
      txc_nxt = txc_r & ~(stat_wr & wd_r[STAT_TXC]);
      if (!sync && tick)
      begin
         tx_ph_nxt = (tx_ph_r == last_ph) ? '0 : tx_ph_r + 4'h1;
      end
      if (tx_bit)
      begin
         case (tx_st_r)
            TX_IDLE:
            begin
               load = txbuf_full_r & ctlb_r[CTLB_TXEN];
            end
            TX_START:
            begin
               txd_nxt = txsh_r[0];
               txsh_nxt = txsh_r >> 1;
               tx_idx_nxt = 4'h1;
               tx_st_nxt = TX_DATA;
            end
            TX_DATA:
            begin
               if (tx_idx_r == nbits)
               begin
                  tx_idx_nxt = '0;
                  tx_st_nxt = (pm != PM_OFF) ? TX_PAR : TX_STOP;
                  txd_nxt = (pm != PM_OFF) ? txpar_r : 1'b1;
               end
               else
               begin
                  txd_nxt = txsh_r[0];
                  txsh_nxt = txsh_r >> 1;
                  tx_idx_nxt = tx_idx_r + 4'h1;
               end
            end
            TX_PAR:
            begin
               txd_nxt = 1'b1;
               tx_st_nxt = TX_STOP;
            end
            default:
            begin
               if (ctlc_r[CTLC_STOP] && tx_idx_r == '0)
               begin
                  tx_idx_nxt = 4'h1;
               end
               else
               begin
                  txc_nxt = 1'b1;
                  tx_st_nxt = TX_IDLE;
                  txd_nxt = 1'b1;
                  load = txbuf_full_r & ctlb_r[CTLB_TXEN];
               end
            end
         endcase
      end
      if (load)
      begin
         txsh_nxt = txbuf_r & data_mask(nbits);
         txpar_nxt = ^(txbuf_r & data_mask(nbits)) ^ pm[0];
         txbuf_full_nxt = 1'b0;
         txd_nxt = 1'b0;
         tx_st_nxt = TX_START;
      end
      if (data_wr && !txbuf_full_r)
      begin
         txbuf_nxt = {ctlb_r[CTLB_NINTH_TRANSMIT_BIT], wd_r};
         txbuf_full_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_st_r <= TX_IDLE;
         txbuf_r <= '0;
         txbuf_full_r <= 1'b0;
         txsh_r <= '0;
         txd_r <= 1'b1;
         txpar_r <= 1'b0;
         tx_idx_r <= '0;
         tx_ph_r <= '0;
         txc_r <= 1'b0;
      end
      else
      begin
         tx_st_r <= tx_st_nxt;
         txbuf_r <= txbuf_nxt;
         txbuf_full_r <= txbuf_full_nxt;
         txsh_r <= txsh_nxt;
         txd_r <= txd_nxt;
         txpar_r <= txpar_nxt;
         tx_idx_r <= tx_idx_nxt;
         tx_ph_r <= tx_ph_nxt;
         txc_r <= txc_nxt;
      end
   end

   // Receiver and two-entry receive buffer
   always_comb
   begin
      logic push;
      logic [10:0] entry;
      push = 1'b0;
      entry = '0;
      rx_st_nxt = rx_st_r;
      rxsh_nxt = rxsh_r;
      rx_idx_nxt = rx_idx_r;
      rx_ph_nxt = rx_ph_r;
      rxpe_nxt = rxpe_r;
      dor_nxt = dor_r & ~pop;
      fifo_nxt = fifo_r;
      cnt_nxt = cnt_r;
      if (!sync && tick)
      begin
         rx_ph_nxt = (rx_ph_r == last_ph) ? '0 : rx_ph_r + 4'h1;
      end
      case (rx_st_r)
         RX_IDLE:
         begin
            rxpe_nxt = 1'b0;
            rx_idx_nxt = '0;
            rxsh_nxt = '0;
            if (sync && smp_edge && !serial_in_line)
            begin
               rx_st_nxt = RX_DATA;
            end
            else if (!sync && tick && !serial_in_line)
            begin
               rx_ph_nxt = 4'h1;
               rx_st_nxt = RX_START;
            end
         end
         RX_START:
         begin
            if (rx_smp)
            begin
               rx_st_nxt = serial_in_line ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA:
         begin
            if (rx_smp)
            begin
               rxsh_nxt[rx_idx_r] = serial_in_line;
               rx_idx_nxt = rx_idx_r + 4'h1;
               if (rx_idx_r + 4'h1 == nbits)
               begin
                  rx_st_nxt = (pm != PM_OFF) ? RX_PAR : RX_STOP;
               end
            end
         end
         RX_PAR:
         begin
            if (rx_smp)
            begin
               rxpe_nxt = serial_in_line ^ (^rxsh_r) ^ pm[0];
               rx_st_nxt = RX_STOP;
            end
         end
         default:
         begin
            if (rx_smp)
            begin
               push = 1'b1;
               entry = {rxpe_r, ~serial_in_line, rxsh_r};
               rx_st_nxt = RX_IDLE;
            end
         end
      endcase
      if (!ctlb_r[CTLB_RXEN])
      begin
         rx_st_nxt = RX_IDLE;
         push = 1'b0;
      end
      if (pop)
      begin
         fifo_nxt[0] = fifo_r[1];
         cnt_nxt = cnt_r - 2'h1;
      end
      if (push)
      begin
         if (cnt_nxt == FIFO_DEPTH)
         begin
            dor_nxt = 1'b1;
         end
         else
         begin
            fifo_nxt[cnt_nxt[0]] = entry;
            cnt_nxt = cnt_nxt + 2'h1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_st_r <= RX_IDLE;
         rxsh_r <= '0;
         rx_idx_r <= '0;
         rx_ph_r <= '0;
         rxpe_r <= 1'b0;
         dor_r <= 1'b0;
         fifo_r[0] <= '0;
         fifo_r[1] <= '0;
         cnt_r <= '0;
         irq_txc_r <= 1'b0;
         irq_emp_r <= 1'b0;
         irq_rxc_r <= 1'b0;
      end
      else
      begin
         rx_st_r <= rx_st_nxt;
         rxsh_r <= rxsh_nxt;
         rx_idx_r <= rx_idx_nxt;
         rx_ph_r <= rx_ph_nxt;
         rxpe_r <= rxpe_nxt;
         dor_r <= dor_nxt;
         fifo_r <= fifo_nxt;
         cnt_r <= cnt_nxt;
         irq_txc_r <= txc_nxt & ctlb_nxt[CTLB_TXCIE];
         irq_emp_r <= ~txbuf_full_nxt & ctlb_nxt[CTLB_EMPTYIE];
         irq_rxc_r <= (cnt_nxt != '0) & ctlb_nxt[CTLB_RXCIE];
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign serial_out_line = txd_r;
   assign transfer_clock_pin_out = xck_r;
   assign transfer_clock_pin_oe = xck_oe_r;
   assign irq_tx_complete = irq_txc_r;
   assign irq_buf_empty = irq_emp_r;
   assign irq_rx_complete = irq_rxc_r;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_BAUD_RELOAD: assert property ((tick && !baudl_wr) |=> bcnt_r == baud_r)
      else $error("baud counter did not reload at zero");
   AST_LOW_WRITE_RELOAD: assert property (baudl_wr |=> bcnt_r == baud_r)
      else $error("baud counter did not reload on low byte write");
   AST_TICK_SPACING: assert property ((tick && baud_nxt != '0 && !baudl_wr) |=> !tick)
      else $error("baud ticks too close");
   AST_PIN_ASYNC_FREE: assert property (!ctlc_r[CTLC_SYNC] |=> !transfer_clock_pin_oe)
      else $error("transfer clock driven in asynchronous mode");
   AST_START_LOW: assert property ((tx_st_r == TX_START) |-> !serial_out_line)
      else $error("start bit not low");
   AST_STOP_IDLE_HIGH: assert property ((tx_st_r inside {TX_IDLE, TX_STOP}) |-> serial_out_line)
      else $error("stop or idle not high");
   AST_SLAVE_LATENCY: assert property ($rose(transfer_clock_pin_in) |-> ##2 (xs2_r && !xs3_r))
      else $error("slave clock edge not seen two cycles later");
   AST_TX_PHASE_WRAP: assert property ((!sync && tick && tx_ph_r == last_ph) |=> tx_ph_r == '0)
      else $error("transmit phase did not wrap");
   AST_DBL_ASYNC_ONLY: assert property (sync |-> !dbl)
      else $error("double speed active in synchronous mode");
   AST_FALSE_START: assert property ((!sync && rx_st_r == RX_START && rx_smp && serial_in_line
      && ctlb_r[CTLB_RXEN]) |=> rx_st_r == RX_IDLE)
      else $error("false start not rejected");
   AST_MASTER_EDGE_ON_TICK: assert property ((sync && master && tx_bit) |-> tick)
      else $error("master change edge off tick");
endmodule

// ===== ucf_peer.sv
// Remote serial transceiver model facing the transmit and receive lines.
// Assumes asynchronous frames timed in whole system clock cycles.
`timescale 1ns/1ns
module ucf_peer
(
   // Clock
   input wire logic aclk,
   // Serial lines
   input wire logic line_in,
   output logic line_out
);
   int bitc = 32;
   int nb = 8;
   logic [1:0] pm = 2'h0;
   logic [8:0] got;
   logic par_got;
   logic stop_got;
   int nrx = 0;
   int i;
   int j;
   initial line_out = 1'b1;
   task automatic put(input logic b);
      line_out <= b;
      repeat (bitc) @(posedge aclk);
   endtask
   // Second argument is the first stop bit; low forces a framing fault
   task automatic send(input logic [8:0] x, input logic s1);
      put(1'b0);
      for (j = 0; j < nb; j++)
         put(x[j]);
      if (pm != 2'h0)
         put(^(x & ((9'h1 << nb) - 9'h1)) ^ (pm == 2'h3));
      put(s1);
      line_out <= 1'b1;
   endtask
   // Mid-bit sampling of frames arriving from the device
   always
   begin
      @(negedge line_in);
      got = 9'h0;
      repeat (bitc / 2) @(posedge aclk);
      for (i = 0; i < nb; i++)
      begin
         repeat (bitc) @(posedge aclk);
         got[i] = line_in;
      end
      if (pm != 2'h0)
      begin
         repeat (bitc) @(posedge aclk);
         par_got = line_in;
      end
      repeat (bitc) @(posedge aclk);
      stop_got = line_in;
      nrx++;
   end
endmodule

// ===== tb_top.sv
// Self-checking bench: register bus master and framing in both directions.
// Assumes the peer model on the serial pair and a 20 MHz clock.
`timescale 1ns/1ns
module tb_top;
   import ucf_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic xin = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sin, sout, ck, oe, ic, ie, ir, p;
   logic [1:0] bresp, rresp, r, pm;
   logic [31:0] rdata, d;
   logic [8:0] v;
   logic [2:0] cs;
   int fails = 0, num_checks = 0, seed = 32'h4fb3, k, n, c, nb;
   always #25 aclk = ~aclk;
   // External transfer clock at one eighth of the system clock
   always
   begin
      repeat (4) @(posedge aclk);
      xin <= ~xin;
   end
   ucf_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .serial_in_line(sin), .serial_out_line(sout), .transfer_clock_pin_in(xin),
      .transfer_clock_pin_out(ck), .transfer_clock_pin_oe(oe), .irq_tx_complete(ic),
      .irq_buf_empty(ie), .irq_rx_complete(ir));
   ucf_peer peer_u (.aclk(aclk), .line_in(sout), .line_out(sin));
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tmo(input int lim);
      if (n >= lim)
      begin
         fails++;
         final_report();
      end
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   function automatic logic [31:0] msk(input logic [8:0] x);
      return 32'(x & ((9'h1 << nb) - 9'h1));
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, x};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (bvalid === 1'b1 && !awvalid && !wvalid)
            break;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      r = bresp;
      bready <= 1'b0;
      tmo(50);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (rvalid === 1'b1 && !arvalid)
            break;
         if (arready)
            arvalid <= 1'b0;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      tmo(50);
   endtask
   task automatic rx_wait;
      for (n = 0; n < 3000 && ir !== 1'b1; n++)
         @(posedge aclk);
      tmo(3000);
   endtask
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_CTLC);
      chk("ctrl_c", 32'h6, d);
      rd(8'h20);
      chk("resp", 32'h2, {30'h0, r});
      wr(8'h20, 8'hff);
      chk("bresp", 32'h2, {30'h0, r});
      chk("pin_oe", 32'h0, {31'h0, oe});
      wr(OFF_BAUDH, 8'h00);
      wr(OFF_BAUDL, 8'h01);
      for (k = 0; k < 8; k++)
      begin
         cs = (k % 5 == 4) ? 3'h7 : 3'(k % 5);
         nb = (cs == 3'h7) ? 9 : 32'(cs) + 5;
         pm = (k % 3 == 0) ? 2'h0 : 2'(k % 3 + 1);
         peer_u.nb = nb;
         peer_u.pm = pm;
         peer_u.bitc = (k > 3) ? 16 : 32;
         v = 9'($random(seed));
         wr(OFF_STAT, {6'h10, k > 3, 1'b0});
         chk("txc clear", 32'h0, {31'h0, ic});
         wr(OFF_CTLC, {2'h0, pm, k[0], cs[1:0], 1'b0});
         wr(OFF_CTLB, {3'h7, 2'h3, cs[2], 1'b0, v[8]});
         c = peer_u.nrx;
         wr(OFF_DATA, v[7:0]);
         for (n = 0; n < 3000 && peer_u.nrx == c; n++)
            @(posedge aclk);
         tmo(3000);
         chk("tx data", msk(v), 32'(peer_u.got));
         if (pm != 2'h0)
            chk("tx parity", 32'(^msk(v) ^ (pm == 2'h3)), 32'(peer_u.par_got));
         chk("tx stop", 32'h1, 32'(peer_u.stop_got));
         peer_u.send(v, 1'b1);
         rx_wait();
         chk("irq", 32'h7, {29'h0, ic, ie, ir});
         rd(OFF_STAT);
         chk("rx status", 32'he0, d & 32'hf4);
         rd(OFF_DATA);
         chk("rx data", msk(v), d);
      end
      peer_u.pm = 2'h3;
      peer_u.send(v, 1'b0);
      rx_wait();
      rd(OFF_STAT);
      chk("rx faults", 32'h94, d & 32'h94);
      rd(OFF_DATA);
      wr(OFF_STAT, 8'h00);
      wr(OFF_CTLC, 8'hc6);
      repeat (4) @(posedge aclk);
      p = ck;
      repeat (2) @(posedge aclk);
      chk("pin clock", {31'h0, ~p}, {31'h0, ck});
      chk("pin_oe", 32'h1, {31'h0, oe});
      wr(OFF_CTLC, 8'h46);
      repeat (2) @(posedge aclk);
      chk("pin_oe slave", 32'h0, {31'h0, oe});
      final_report();
   end
endmodule
